// File: pkg/ivf_consts.svh
`ifndef IVF_CONSTS_SVH
`define IVF_CONSTS_SVH

// Register indices; byte address is four times the index
`define IVF_IDX_PRIO        6'h09
`define IVF_IDX_BASE        6'h0a
`define IVF_IDX_MATCH0      6'h0b
`define IVF_IDX_F0_LOW      6'h0c
`define IVF_IDX_F0_HIGH     6'h0d
`define IVF_IDX_MATCH1      6'h0e
`define IVF_IDX_F1_LOW      6'h0f
`define IVF_IDX_F1_HIGH     6'h10
`define IVF_IDX_PEND0       6'h11
`define IVF_IDX_PEND5       6'h16

// Priority field positions (low bit of each two-bit field)
`define IVF_CONV_A_LIMIT_LSB 6
`define IVF_CONV_B_LIMIT_LSB 4
`define IVF_CONV_A_DONE_LSB  2
`define IVF_CONV_B_DONE_LSB  0

// Implemented field widths
`define IVF_BASE_W          13
`define IVF_MATCH_W         7
`define IVF_HIGH_W          5
`define IVF_LOW_W           16

// Reset values
`define IVF_RST_PRIO        8'h00
`define IVF_RST_BASE        13'h0000
`define IVF_RST_MATCH       7'h00
`define IVF_RST_LOW         16'h0000
`define IVF_RST_HIGH        5'h00
`define IVF_RST_VADDR       21'h00_0000

// Priority codes
`define IVF_IPL_OFF         2'h0
`define IVF_IPL_TOP         2'h3

// Vector range that has pending bits
`define IVF_VEC_FIRST       2
`define IVF_VEC_LAST        81

`endif

// File: pkg/ivf_pkg.sv
package ivf_pkg;

  typedef logic [1:0]  ivf_ipl_t;
  typedef logic [6:0]  ivf_vec_t;
  typedef logic [20:0] ivf_vaddr_t;
  typedef logic [15:0] ivf_word_t;

endpackage : ivf_pkg

// File: verilog/ivf_vector_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
`include "ivf_consts.svh"

// Functional notes
// - Priority code 00 off, 01-11 levels 0-2
// - Four converter priority fields at 7-6,5-4,3-2,1-0
// - Converter fields reset disabled, max level two
// - Unused upper bits read zero, ignore writes
// - Base field forms upper 13 address bits
// - Winner vector number forms bits 7-1, bit 0 zero
// - Match register zero selects fast channel 0
// - Fast hit drives its own vector address
// - Fast requests outrank all other level two
// - Fast channel 0 beats fast channel 1
// - Channel 0 low register gives bits 15-0
// - Channel 0 high register gives bits 20-16
// - Match register one selects fast channel 1
// - Channel 1 low/high form 21-bit address
// - Six pending banks cover vectors 2-81
// - Pending bit reads 0 when request pending
// - Banks ordered by ascending vector number
// - First bank bit 0 reads one always
module ivf_vector_ctrl
  import ivf_pkg::*;
#(
  parameter ivf_vec_t CONV_A_LIMIT_VEC = 7'h40,
  parameter ivf_vec_t CONV_B_LIMIT_VEC = 7'h41,
  parameter ivf_vec_t CONV_A_DONE_VEC  = 7'h42,
  parameter ivf_vec_t CONV_B_DONE_VEC  = 7'h43
) (
  // Clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic                      pready,
  output logic [31:0]               prdata,
  output logic                      pslverr,
  // Interrupt sources, index is vector number
  input  wire logic [81:2]          irq_req,
  input  wire logic [81:2][1:0]     irq_src_level,
  // Core side
  output logic [20:0]               vector_address_bus,
  output logic                      irq_active,
  output logic [1:0]                irq_level,
  output logic                      irq_fast
);

  // Register state
  ivf_ipl_t                conv_a_limit_priority_reg;
  ivf_ipl_t                conv_b_limit_priority_reg;
  ivf_ipl_t                conv_a_done_priority_reg;
  ivf_ipl_t                conv_b_done_priority_reg;
  logic [`IVF_BASE_W-1:0]  vector_base_reg;
  ivf_vec_t                fast_match_zero_reg;
  ivf_vec_t                fast_match_one_reg;
  logic [`IVF_LOW_W-1:0]   fast_zero_vector_low_reg;
  logic [`IVF_HIGH_W-1:0]  fast_zero_vector_high_reg;
  logic [`IVF_LOW_W-1:0]   fast_one_vector_low_reg;
  logic [`IVF_HIGH_W-1:0]  fast_one_vector_high_reg;
  logic [81:2]             pending_reg;

  // Bus handshake state
  logic                    pready_reg;
  logic [31:0]             prdata_reg;
  logic                    pslverr_reg;

  // Core side state
  ivf_vaddr_t              vaddr_reg;
  logic                    active_reg;
  ivf_ipl_t                level_reg;
  logic                    fast_reg;

  // Derived signals
  logic [127:0]            pend_pad;
  ivf_ipl_t                eff_lvl [128];
  logic [95:0]             pend_flat;
  logic [15:0]             pend_bank [6];
  logic                    acc_phase;
  logic                    wr_take;
  logic [5:0]              reg_idx;
  logic                    idx_ok;
  logic                    best_any;
  ivf_ipl_t                best_lvl;
  ivf_vec_t                best_vec;
  logic                    f0_hit;
  logic                    f1_hit;
  ivf_vaddr_t              vaddr_next;
  ivf_ipl_t                level_next;

  function automatic logic mapped(input logic [5:0] idx);
    mapped = (idx >= `IVF_IDX_PRIO) && (idx <= `IVF_IDX_PEND5);
  endfunction : mapped

  function automatic logic in_table(input ivf_vec_t v);
    in_table = (v >= 7'(`IVF_VEC_FIRST)) && (v <= 7'(`IVF_VEC_LAST));
  endfunction : in_table

  // Write strobe for one register index
  function automatic logic wr_hit(input logic [5:0] idx);
    wr_hit = wr_take && (reg_idx == idx);
  endfunction : wr_hit

  // A fast channel needs a table vector that is pending and enabled
  function automatic logic fast_hit(input ivf_vec_t v);
    fast_hit = in_table(v) && pend_pad[v] && (eff_lvl[v] != `IVF_IPL_OFF);
  endfunction : fast_hit

  assign acc_phase = psel && penable;
  // Writes land only at the edge where pready is seen high
  assign wr_take   = acc_phase && pready_reg && pwrite && idx_ok;
  assign reg_idx   = paddr[7:2];
  assign idx_ok    = mapped(reg_idx) && (paddr[1:0] == 2'h0);

  // Live request snapshot; software cannot touch it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending_reg <= '0;
    end else begin
      pending_reg <= irq_req;
    end
  end

  // Active-low image, reserved positions read as one
  assign pend_pad  = {46'h0, pending_reg, 2'h0};
  assign pend_flat = {15'h7fff, ~pending_reg, 1'b1};

  generate
    for (genvar b = 0; b < 6; b++) begin : g_bank
      assign pend_bank[b] = pend_flat[16*b +: 16];
    end
  endgenerate

  // Effective priority per vector; converter sources use local fields
  generate
    for (genvar v = 0; v < 128; v++) begin : g_lvl
      if (v < `IVF_VEC_FIRST || v > `IVF_VEC_LAST) begin : g_none
        assign eff_lvl[v] = `IVF_IPL_OFF;
      end else begin : g_src
        assign eff_lvl[v] =
          (7'(v) == CONV_A_LIMIT_VEC) ? conv_a_limit_priority_reg :
          (7'(v) == CONV_B_LIMIT_VEC) ? conv_b_limit_priority_reg :
          (7'(v) == CONV_A_DONE_VEC)  ? conv_a_done_priority_reg  :
          (7'(v) == CONV_B_DONE_VEC)  ? conv_b_done_priority_reg  :
                                        irq_src_level[v];
      end
    end
  endgenerate

  // Table winner: highest code, lowest vector number on a tie
  always_comb begin
    best_any = 1'b0;
    best_lvl = `IVF_IPL_OFF;
    best_vec = 7'h00;
    for (int i = `IVF_VEC_LAST; i >= `IVF_VEC_FIRST; i--) begin
      // Code 00 never competes
      if (pend_pad[i] && eff_lvl[i] != `IVF_IPL_OFF && eff_lvl[i] >= best_lvl) begin
        best_any = 1'b1;
        best_lvl = eff_lvl[i];
        best_vec = 7'(i);
      end
    end
  end

  // Fast channels; a misprogrammed level is the user's hazard
  always_comb begin
    f0_hit = fast_hit(fast_match_zero_reg);
    f1_hit = fast_hit(fast_match_one_reg);
  end

  always_comb begin
    vaddr_next = vaddr_reg;
    level_next = 2'h0;
    // Fast hits sit above every table level two request
    if (f0_hit) begin
      vaddr_next = {fast_zero_vector_high_reg, fast_zero_vector_low_reg};
      level_next = 2'h2;
    end else if (f1_hit) begin
      vaddr_next = {fast_one_vector_high_reg, fast_one_vector_low_reg};
      level_next = 2'h2;
    end else if (best_any) begin
      vaddr_next = {vector_base_reg, best_vec, 1'b0};
      level_next = best_lvl - 2'h1;
    end
  end

  // Address held after the request drops so the core sees a stable bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vaddr_reg <= `IVF_RST_VADDR;
    end else begin
      vaddr_reg <= vaddr_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_reg <= 1'b0;
    end else begin
      active_reg <= f0_hit || f1_hit || best_any;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_reg <= 2'h0;
    end else begin
      level_reg <= level_next;
    end
  end

  // Fast flag tells the core to skip the jump table
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_reg <= 1'b0;
    end else begin
      fast_reg <= f0_hit || f1_hit;
    end
  end

  // Converter priority fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {conv_a_limit_priority_reg, conv_b_limit_priority_reg,
       conv_a_done_priority_reg, conv_b_done_priority_reg} <= `IVF_RST_PRIO;
    end else if (wr_hit(`IVF_IDX_PRIO) && pstrb[0]) begin
      conv_a_limit_priority_reg <= pwdata[`IVF_CONV_A_LIMIT_LSB +: 2];
      conv_b_limit_priority_reg <= pwdata[`IVF_CONV_B_LIMIT_LSB +: 2];
      conv_a_done_priority_reg  <= pwdata[`IVF_CONV_A_DONE_LSB +: 2];
      conv_b_done_priority_reg  <= pwdata[`IVF_CONV_B_DONE_LSB +: 2];
    end
  end

  // Vector base; only bits 12-0 are stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vector_base_reg <= `IVF_RST_BASE;
    end else if (wr_hit(`IVF_IDX_BASE)) begin
      if (pstrb[0]) begin
        vector_base_reg[7:0] <= pwdata[7:0];
      end
      if (pstrb[1]) begin
        vector_base_reg[12:8] <= pwdata[12:8];
      end
    end
  end

  // Fast match registers; only the vector number field is stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_match_zero_reg <= `IVF_RST_MATCH;
    end else if (wr_hit(`IVF_IDX_MATCH0) && pstrb[0]) begin
      fast_match_zero_reg <= pwdata[6:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_match_one_reg <= `IVF_RST_MATCH;
    end else if (wr_hit(`IVF_IDX_MATCH1) && pstrb[0]) begin
      fast_match_one_reg <= pwdata[6:0];
    end
  end

  // Fast vector address registers, one block per register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_zero_vector_low_reg <= `IVF_RST_LOW;
    end else if (wr_hit(`IVF_IDX_F0_LOW)) begin
      if (pstrb[0]) begin
        fast_zero_vector_low_reg[7:0] <= pwdata[7:0];
      end
      if (pstrb[1]) begin
        fast_zero_vector_low_reg[15:8] <= pwdata[15:8];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_zero_vector_high_reg <= `IVF_RST_HIGH;
    end else if (wr_hit(`IVF_IDX_F0_HIGH) && pstrb[0]) begin
      fast_zero_vector_high_reg <= pwdata[4:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_one_vector_low_reg <= `IVF_RST_LOW;
    end else if (wr_hit(`IVF_IDX_F1_LOW)) begin
      if (pstrb[0]) begin
        fast_one_vector_low_reg[7:0] <= pwdata[7:0];
      end
      if (pstrb[1]) begin
        fast_one_vector_low_reg[15:8] <= pwdata[15:8];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_one_vector_high_reg <= `IVF_RST_HIGH;
    end else if (wr_hit(`IVF_IDX_F1_HIGH) && pstrb[0]) begin
      fast_one_vector_high_reg <= pwdata[4:0];
    end
  end

  // Read mux; unused upper bits come back zero
  function automatic ivf_word_t read_word(input logic [5:0] idx);
    read_word = 16'h0000;
    unique case (idx)
      `IVF_IDX_PRIO:    read_word = {8'h00, conv_a_limit_priority_reg,
                                     conv_b_limit_priority_reg,
                                     conv_a_done_priority_reg,
                                     conv_b_done_priority_reg};
      `IVF_IDX_BASE:    read_word = {3'h0, vector_base_reg};
      `IVF_IDX_MATCH0:  read_word = {9'h000, fast_match_zero_reg};
      `IVF_IDX_F0_LOW:  read_word = fast_zero_vector_low_reg;
      `IVF_IDX_F0_HIGH: read_word = {11'h000, fast_zero_vector_high_reg};
      `IVF_IDX_MATCH1:  read_word = {9'h000, fast_match_one_reg};
      `IVF_IDX_F1_LOW:  read_word = fast_one_vector_low_reg;
      `IVF_IDX_F1_HIGH: read_word = {11'h000, fast_one_vector_high_reg};
      default: begin
        if (idx >= `IVF_IDX_PEND0 && idx <= `IVF_IDX_PEND5) begin
          read_word = pend_bank[3'(idx - `IVF_IDX_PEND0)];
        end
      end
    endcase
  endfunction : read_word

  // One wait state: data is captured in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= acc_phase && !pready_reg;
    end
  end

  // Error flag and read data stand only beside pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_reg <= 1'b0;
    end else begin
      pslverr_reg <= acc_phase && !pready_reg && !idx_ok;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (acc_phase && !pready_reg && !pwrite && idx_ok) begin
      prdata_reg <= {16'h0000, read_word(reg_idx)};
    end else begin
      prdata_reg <= 32'h0000_0000;
    end
  end

  assign pready             = pready_reg;
  assign prdata             = prdata_reg;
  assign pslverr            = pslverr_reg;
  assign vector_address_bus = vaddr_reg;
  assign irq_active         = active_reg;
  assign irq_level          = level_reg;
  assign irq_fast           = fast_reg;

endmodule : ivf_vector_ctrl

`default_nettype wire

// File: dv/ivf_vector_ctrl_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module ivf_vector_ctrl_monitor (
  // APB
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  // Core side
  input wire logic [81:2] irq_req,
  input wire logic [20:0] vector_address_bus,
  input wire logic        irq_active,
  input wire logic [1:0]  irq_level,
  input wire logic        irq_fast
);
  default clocking mon_cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  apb_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("access phase not answered after one wait state");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  unmapped_err_a: assert property (psel && penable && !pready && (paddr < 8'h24 || paddr > 8'h58)
    |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access without error");
  base_upper_a: assert property (pready && !pwrite && paddr == 8'h28 |-> prdata[31:13] == 19'h0_0000)
    else $error("base upper bits not zero");
  match_upper_a: assert property (pready && !pwrite &&
    (paddr == 8'h2c || paddr == 8'h38) |-> prdata[15:7] == 9'h000)
    else $error("match upper bits not zero");
  pend_spare_a: assert property (pready && !pwrite && paddr == 8'h44 |-> prdata[0])
    else $error("spare pending bit reads zero");
  pend_top_a: assert property (pready && !pwrite && paddr == 8'h58 |-> prdata[15:1] == 15'h7fff)
    else $error("pending bits beyond last vector not one");
  level_cap_a: assert property (irq_active |-> irq_level != 2'h3)
    else $error("winner level above two");
  fast_top_a: assert property (irq_fast |-> irq_active && irq_level == 2'h2)
    else $error("fast winner not at level two");
  table_even_a: assert property (irq_active && !irq_fast |-> !vector_address_bus[0])
    else $error("table address not on an even slot");
  quiet_idle_a: assert property ((irq_req == '0)[*3] |=> !irq_active && irq_level == 2'h0)
    else $error("winner reported with no requests");
endmodule : ivf_vector_ctrl_monitor

bind ivf_vector_ctrl ivf_vector_ctrl_monitor u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .prdata(prdata), .irq_req(irq_req),
  .vector_address_bus(vector_address_bus), .irq_active(irq_active), .irq_level(irq_level),
  .irq_fast(irq_fast));
`default_nettype wire

// File: dv/ivf_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module ivf_core_model (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Vector inputs from the controller
  input  wire logic [20:0] vector_address_bus,
  input  wire logic        irq_active,
  input  wire logic        irq_fast,
  input  wire logic [1:0]  irq_level,
  // One pulse per new winner, with what the core would jump on
  output logic             taken,
  output logic [23:0]      taken_info
);
  logic        act_q;
  logic [20:0] addr_q;

  // New winner is a rising request or a changed address while active
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_q      <= 1'b0;
      addr_q     <= '0;
      taken      <= 1'b0;
      taken_info <= '0;
    end else begin
      act_q      <= irq_active;
      addr_q     <= vector_address_bus;
      taken      <= irq_active && (!act_q || addr_q != vector_address_bus);
      taken_info <= {irq_fast, irq_level, vector_address_bus};
    end
  end
endmodule : ivf_core_model
`default_nettype wire

// File: dv/irq_vector_fast_pending_test.sv
`timescale 1ns/1ns
`default_nettype none
module irq_vector_fast_pending_test;
  import ivf_pkg::*;
  logic             pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic             irq_active, irq_fast, taken;
  logic [7:0]       paddr;
  logic [31:0]      pwdata, prdata, seed;
  logic [81:2]      irq_req;
  logic [81:2][1:0] irq_src_level;
  logic [20:0]      vector_address_bus;
  logic [1:0]       irq_level;
  logic [3:0]       pstrb;
  logic [23:0]      taken_info;
  logic [32:0]      rq[$];
  logic [23:0]      cq[$];
  int               miscompares, n_checks;

  ivf_vector_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .irq_req(irq_req), .irq_src_level(irq_src_level),
    .vector_address_bus(vector_address_bus), .irq_active(irq_active), .irq_level(irq_level),
    .irq_fast(irq_fast));
  ivf_core_model u_core (.pclk(pclk), .presetn(presetn), .vector_address_bus(vector_address_bus),
    .irq_active(irq_active), .irq_fast(irq_fast), .irq_level(irq_level), .taken(taken),
    .taken_info(taken_info));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task end_sim;
    $display("checks %0d, miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim

  task chk(input logic [32:0] got, input logic [32:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Request held until pready is seen, then one idle cycle
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      end_sim();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task rd(input logic [7:0] a, input logic [32:0] e);
    rq.push_back(e);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd

  // Latency is fixed at two edges, so six cycles settle each way
  task fire(input logic [81:2] r, input logic has, input logic [23:0] e);
    if (has) cq.push_back(e);
    irq_req <= r;
    repeat (6) @(posedge pclk);
    irq_req <= '0;
    repeat (6) @(posedge pclk);
    chk(33'(cq.size()), 33'h0_0000_0000);
  endtask : fire

  function automatic logic [20:0] ta(input int v);
    return {13'h0001, v[6:0], 1'b0};
  endfunction : ta

  function automatic logic [81:2] bit_of(input int v);
    bit_of = '0;
    bit_of[v] = 1'b1;
  endfunction : bit_of

  function automatic logic [15:0] mask(input int i);
    case (i)
      9: return 16'h00ff;
      10: return 16'h1fff;
      11, 14: return 16'h007f;
      13, 16: return 16'h001f;
      default: return 16'hffff;
    endcase
  endfunction : mask

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  always @(posedge pclk) begin
    if (pready === 1'b1 && pwrite === 1'b0)
      chk({pslverr, prdata}, rq.size() ? rq.pop_front() : 33'h1_ffff_ffff);
    if (taken === 1'b1)
      chk(33'(taken_info), cq.size() ? 33'(cq.pop_front()) : 33'h1_ffff_ffff);
  end

  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    end_sim();
  end

  initial begin
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0000_0000;
    irq_req = '0; irq_src_level = {80{2'h3}}; presetn = 1'b0; seed = 32'h017d_83b6;
    miscompares = 0; n_checks = 0; pstrb = 4'hf;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 9; i <= 22; i++) rd(8'(i * 4), (i > 16) ? 33'h0_0000_ffff : 33'h0_0000_0000);
    rd(8'h5c, 33'h1_0000_0000);
    rd(8'h25, 33'h1_0000_0000);
    fire(bit_of(64), 1'b0, '0);
    for (int i = 9; i <= 16; i++) begin
      seed = lfsr(seed);
      apb(1'b1, 8'(i * 4), seed);
      rd(8'(i * 4), {17'h0_0000, seed[15:0] & mask(i)});
    end
    apb(1'b1, 8'h44, 32'h0000_0000);
    rd(8'h44, 33'h0_0000_ffff);
    apb(1'b1, 8'h24, 32'h0000_0000);
    apb(1'b1, 8'h28, 32'h0000_0001);
    apb(1'b1, 8'h2c, 32'h0000_0009);
    apb(1'b1, 8'h30, 32'h0000_beef);
    apb(1'b1, 8'h34, 32'h0000_0015);
    apb(1'b1, 8'h38, 32'h0000_000a);
    apb(1'b1, 8'h3c, 32'h0000_1234);
    apb(1'b1, 8'h40, 32'h0000_000a);
    fire(bit_of(5), 1'b1, {1'b0, 2'h2, ta(5)});
    for (int c = 0; c < 4; c++) begin
      irq_src_level[7] <= 2'(c);
      fire(bit_of(7) | bit_of(8), 1'b1, {1'b0, c ? 2'(c - 1) : 2'h2, ta(c ? 7 : 8)});
      irq_src_level[8] <= 2'h0;
    end
    // Fast requests kept at level two as software must
    fire(bit_of(3) | bit_of(10), 1'b1, {1'b1, 2'h2, 5'h0a, 16'h1234});
    fire(bit_of(9) | bit_of(10), 1'b1, {1'b1, 2'h2, 5'h15, 16'hbeef});
    apb(1'b1, 8'h24, 32'h0000_00e4);
    fire(bit_of(67), 1'b0, '0);
    fire(bit_of(66), 1'b1, {1'b0, 2'h0, ta(66)});
    fire(bit_of(64) | bit_of(65) | bit_of(66) | bit_of(67), 1'b1, {1'b0, 2'h2, ta(64)});
    irq_src_level[2] <= 2'h0; irq_src_level[17] <= 2'h0;
    irq_src_level[33] <= 2'h0; irq_src_level[81] <= 2'h0;
    irq_req <= bit_of(2) | bit_of(17) | bit_of(33) | bit_of(81);
    repeat (3) @(posedge pclk);
    rd(8'h44, 33'h0_0000_fffd);
    rd(8'h48, 33'h0_0000_fffe);
    rd(8'h4c, 33'h0_0000_fffe);
    rd(8'h58, 33'h0_0000_fffe);
    irq_req <= '0;
    repeat (4) @(posedge pclk);
    // Low lane only: the upper byte keeps its value
    pstrb <= 4'h1;
    apb(1'b1, 8'h3c, 32'h0000_5678);
    pstrb <= 4'hf;
    rd(8'h3c, 33'h0_0000_1278);
    chk(33'(rq.size() + cq.size()), 33'h0_0000_0000);
    end_sim();
  end
endmodule : irq_vector_fast_pending_test
`default_nettype wire
